/* File: design/adcop_buf.sv */
// two-entry result buffer with valid and ready on both sides
// assumes both sides on sys_clk_i
`timescale 1ns/10ps
module adcop_buf
    import adcop_pkg::*;
#(
    parameter int W = DW
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    logic [W-1:0] mem_r [2];
    logic         wptr_r;
    logic         rptr_r;
    logic [1:0]   cnt_r;
    logic         push;
    logic         pop;

    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign in_ready_o  = (cnt_r != 2'h2);
    assign out_valid_o = (cnt_r != 2'h0);
    assign out_data_o  = mem_r[rptr_r];

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_r[wptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wptr_r <= 1'b0;
            rptr_r <= 1'b0;
            cnt_r  <= 2'h0;
        end else begin
            if (push) begin
                wptr_r <= ~wptr_r;
            end
            if (pop) begin
                rptr_r <= ~rptr_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

/* File: design/adcop_pkg.sv */
// constants, pin positions and types of the converter result output port
// assumes a single sampling clock and one external serial clock pin
package adcop_pkg;
    localparam int          DW              = 16;
    localparam logic [15:0] RST_WORD        = 16'h0000;
    // internal serial clock: four system cycles per bit
    localparam logic [1:0]  PH_LAST         = 2'h3;
    localparam logic [1:0]  PH_SCLK_RISE    = 2'h0;
    localparam logic [1:0]  PH_SCLK_FALL    = 2'h2;
    localparam logic [3:0]  MBIT_LAST       = 4'hf;
    localparam logic [4:0]  CHAIN_DELAY     = 5'h10;
    localparam logic [4:0]  LBIT_LAST       = 5'h0f;
    // positions in the synchronised input vector
    localparam int          SI_SER          = 0;
    localparam int          SI_EXT          = 1;
    localparam int          SI_FRAME_POLARITY_SELECT      = 2;
    localparam int          SI_CLOCK_INVERT_SELECT      = 3;
    localparam int          SI_RDC          = 4;
    localparam int          SI_COD          = 5;
    localparam int          SI_CS_N         = 6;
    localparam int          SI_RD_N         = 7;
    localparam int          NSYNC           = 8;
    // shared data pin positions
    localparam int          PIN_SERIAL_RESULT_OUT = 8;
    localparam int          PIN_SCLK        = 9;
    localparam int          PIN_FRAME_SYNC  = 10;
    localparam int          PIN_INCOMPLETE  = 11;
    localparam logic [15:0] OE_ALWAYS       = 16'hf000;
    localparam logic [15:0] OE_SER_MASK     = 16'h0f00;

    typedef enum logic [0:0] {
        M_IDLE  = 1'b0,
        M_SHIFT = 1'b1
    } adcop_mst_t;
endpackage

/* File: design/adcop_top.sv */
// result output port: parallel bus or serial master/slave port
// assumes results arrive on sys_clk_i; ext_sclk_i is the host serial clock pin
//
// Overview of operation
// - parallel mode drives bits 0-11 as data
// - bits 12-15 are always driven outputs
// - slave: chain-in reappears sixteen periods later
// - master read timing chosen by read-mode pin
// - result shifted out most significant bit first
// - master output stable across both clock edges
// - slave update edge chosen by clock inversion
// - clock pin output in master, input in slave
// - frame sync active while master data valid
// - slave read overrun loads the new word, pulses flag
// - drivers of bits 0-11 enabled only with select and read low
// - chip select gates the external clock
// - coding select high binary, low MSB inverted
// - busy from start until result latched
`timescale 1ns/10ps
module adcop_top
    import adcop_pkg::*;
(
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    input  wire logic          ext_sclk_i,
    input  wire logic          conv_start_i,
    input  wire logic          res_valid_i,
    output logic               res_ready_o,
    input  wire logic [DW-1:0] res_data_i,
    output logic               busy_o,
    input  wire logic          serial_mode_select_i,
    input  wire logic          output_coding_select_i,
    input  wire logic          cs_n_i,
    input  wire logic          rd_n_i,
    input  wire logic [7:4]    pin_d_i,
    output logic [15:0]        pin_d_o,
    output logic [15:0]        pin_d_oe_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic [NSYNC-1:0] sync_a_r;
    logic [NSYNC-1:0] sync_b_r;
    logic             ser;
    logic             clock_source_select;
    logic             frame_polarity_select;
    logic             clock_invert_select;
    logic             read_mode_sel;
    logic             coding;
    logic             out_en;

    // pins are asynchronous to sys_clk_i
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_a_r <= '0;
            sync_b_r <= '0;
        end else begin
            sync_a_r <= {rd_n_i, cs_n_i, output_coding_select_i, pin_d_i,
                         serial_mode_select_i};
            sync_b_r <= sync_a_r;
        end
    end

    assign ser                   = sync_b_r[SI_SER];
    assign clock_source_select   = sync_b_r[SI_EXT];
    assign frame_polarity_select = sync_b_r[SI_FRAME_POLARITY_SELECT];
    assign clock_invert_select   = sync_b_r[SI_CLOCK_INVERT_SELECT];
    assign read_mode_sel         = sync_b_r[SI_RDC];
    assign coding                = sync_b_r[SI_COD];
    assign out_en = !sync_b_r[SI_CS_N] && !sync_b_r[SI_RD_N];

    ////////////////////////////////////////////////////////////////////////////
    logic          buf_valid;
    logic          buf_ready;
    logic [DW-1:0] buf_data;
    logic          load;
    logic [DW-1:0] word_r;
    logic          busy_r;
    logic          data_new_r;
    adcop_mst_t    m_state_r;
    logic          m_start;

    adcop_buf #(
        .W (DW)
    ) u_buf (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (res_valid_i),
        .in_ready_o  (res_ready_o),
        .in_data_i   (res_data_i),
        .out_valid_o (buf_valid),
        .out_ready_i (buf_ready),
        .out_data_o  (buf_data)
    );

    // a master frame in flight stalls the buffer so its word stays put
    assign buf_ready = !(m_state_r == M_SHIFT);
    assign load      = buf_valid && buf_ready;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            word_r <= RST_WORD;
        end else if (load) begin
            word_r <= {buf_data[DW-1] ^ !coding, buf_data[DW-2:0]};
        end
    end

    // set wins over the clear when both land together
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
        end else if (conv_start_i) begin
            busy_r <= 1'b1;
        end else if (load) begin
            busy_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_new_r <= 1'b0;
        end else if (load) begin
            data_new_r <= 1'b1;
        end else if (m_start) begin
            data_new_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0]    m_ph_r;
    logic [3:0]    m_bit_r;
    logic [DW-1:0] m_sh_r;
    logic          m_sdo_r;
    logic          m_sclk_r;
    logic          m_sync_r;

    assign m_start = ser && !clock_source_select && out_en && data_new_r
                     && (m_state_r == M_IDLE)
                     && (read_mode_sel || !busy_r);

    // master frame: sixteen bits of four phases each
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            m_state_r <= M_IDLE;
            m_ph_r    <= 2'h0;
            m_bit_r   <= 4'h0;
            m_sh_r    <= RST_WORD;
            m_sdo_r   <= 1'b0;
            m_sync_r  <= 1'b0;
        end else begin
            case (m_state_r)
                M_IDLE: begin
                    if (m_start) begin
                        m_state_r <= M_SHIFT;
                        m_ph_r    <= 2'h0;
                        m_bit_r   <= 4'h0;
                        m_sh_r    <= {word_r[DW-2:0], 1'b0};
                        m_sdo_r   <= word_r[DW-1];
                        m_sync_r  <= 1'b1;
                    end
                end
                M_SHIFT: begin
                    m_ph_r <= m_ph_r + 2'h1;
                    if (m_ph_r == PH_LAST) begin
                        if (m_bit_r == MBIT_LAST) begin
                            m_state_r <= M_IDLE;
                            m_sync_r  <= 1'b0;
                        end else begin
                            m_bit_r <= m_bit_r + 4'h1;
                            // change only with the clock low, clear of both edges
                            m_sdo_r <= m_sh_r[DW-1];
                            m_sh_r  <= {m_sh_r[DW-2:0], 1'b0};
                        end
                    end
                end
                default: begin
                    m_state_r <= M_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            m_sclk_r <= 1'b0;
        end else if (m_state_r == M_SHIFT && m_ph_r == PH_SCLK_RISE) begin
            m_sclk_r <= 1'b1;
        end else if (m_ph_r == PH_SCLK_FALL || m_state_r == M_IDLE) begin
            m_sclk_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link side on the host clock; word_r is read only on the first edge of a frame
    logic          l_clk;
    logic          l_rst;
    logic [4:0]    l_cnt_r;
    logic [DW-1:0] l_sh_r;
    logic          l_sdo_r;
    logic          l_start_tgl_r;
    logic          l_done_tgl_r;

    // inversion moves the update edge; the strap is static in use
    assign l_clk = ext_sclk_i ^ clock_invert_select;
    assign l_rst = rst_i || cs_n_i;

    always_ff @(posedge l_clk or posedge l_rst) begin
        if (l_rst) begin
            l_cnt_r <= 5'h00;
            l_sh_r  <= RST_WORD;
            l_sdo_r <= 1'b0;
        end else begin
            if (l_cnt_r != CHAIN_DELAY) begin
                l_cnt_r <= l_cnt_r + 5'h01;
            end
            if (l_cnt_r == 5'h00) begin
                l_sdo_r <= word_r[DW-1];
                l_sh_r  <= {word_r[DW-2:0], pin_d_i[SI_RDC+3]};
            end else begin
                l_sdo_r <= l_sh_r[DW-1];
                l_sh_r  <= {l_sh_r[DW-2:0], pin_d_i[SI_RDC+3]};
            end
        end
    end

    // toggles survive chip select so the crossing stays in step
    always_ff @(posedge l_clk or posedge rst_i) begin
        if (rst_i) begin
            l_start_tgl_r <= 1'b0;
            l_done_tgl_r  <= 1'b0;
        end else if (!cs_n_i) begin
            if (l_cnt_r == 5'h00) begin
                l_start_tgl_r <= ~l_start_tgl_r;
            end
            if (l_cnt_r == LBIT_LAST) begin
                l_done_tgl_r <= ~l_done_tgl_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [2:0] st_s_r;
    logic [2:0] dn_s_r;
    logic       rd_active_r;
    logic       incomplete_read_flag_r;
    logic       overrun;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_s_r <= 3'h0;
            dn_s_r <= 3'h0;
        end else begin
            st_s_r <= {st_s_r[1:0], l_start_tgl_r};
            dn_s_r <= {dn_s_r[1:0], l_done_tgl_r};
        end
    end

    assign overrun = ser && clock_source_select && rd_active_r && load;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_active_r <= 1'b0;
        end else if (st_s_r[2] ^ st_s_r[1]) begin
            rd_active_r <= 1'b1;
        end else if ((dn_s_r[2] ^ dn_s_r[1]) || overrun) begin
            rd_active_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            incomplete_read_flag_r <= 1'b0;
        end else begin
            incomplete_read_flag_r <= overrun;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] pin_o_r;
    logic [15:0] pin_oe_r;
    logic        ser_slave_r;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_o_r     <= RST_WORD;
            pin_oe_r    <= OE_ALWAYS;
            ser_slave_r <= 1'b0;
        end else begin
            ser_slave_r <= ser && clock_source_select;
            pin_o_r     <= word_r;
            pin_oe_r    <= OE_ALWAYS;
            if (!ser) begin
                pin_oe_r <= {16{out_en}} | OE_ALWAYS;
            end else begin
                pin_o_r[PIN_SERIAL_RESULT_OUT] <= m_sdo_r;
                pin_o_r[PIN_SCLK]       <= m_sclk_r ^ clock_invert_select;
                pin_o_r[PIN_FRAME_SYNC] <= m_sync_r ^ frame_polarity_select;
                pin_o_r[PIN_INCOMPLETE] <= incomplete_read_flag_r;
                pin_oe_r[PIN_SERIAL_RESULT_OUT] <= out_en;
                pin_oe_r[PIN_SCLK]       <= out_en && !clock_source_select;
                pin_oe_r[PIN_FRAME_SYNC] <= out_en && !clock_source_select;
                pin_oe_r[PIN_INCOMPLETE] <= out_en && clock_source_select;
            end
        end
    end

    // serial data in slave mode comes from the link-side flop
    always_comb begin
        pin_d_o = pin_o_r;
        if (ser_slave_r) begin
            pin_d_o[PIN_SERIAL_RESULT_OUT] = l_sdo_r;
        end
    end

    assign pin_d_oe_o = pin_oe_r;
    assign busy_o     = busy_r;

    ////////////////////////////////////////////////////////////////////////////
    a_busy_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        conv_start_i |=> busy_r)
        else $error("busy not raised after start");
    a_busy_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        busy_r && !load && !conv_start_i |=> busy_r)
        else $error("busy dropped before latch");
    a_high_bits_on: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ##1 (pin_oe_r[15:12] == 4'hf))
        else $error("upper data pins not driven");
    a_par_bits: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !ser |=> pin_o_r[11:7] == $past(word_r[11:7]))
        else $error("parallel bits wrong");
    a_oe_gated: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !out_en |=> (pin_oe_r[11:0] == 12'h000))
        else $error("drivers on without select and read");
    a_coding_msb: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        load |=> word_r[DW-1] == ($past(buf_data[DW-1]) ^ !$past(coding)))
        else $error("output coding wrong");
    a_sync_window: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        m_sync_r == (m_state_r == M_SHIFT))
        else $error("frame sync not tied to frame");
    a_frame_len: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(m_state_r == M_SHIFT) |-> ##63 (m_state_r == M_SHIFT)
        ##1 (m_state_r == M_IDLE))
        else $error("master frame not sixteen bits");
    a_sdo_stable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (m_state_r == M_SHIFT) && (m_ph_r != 2'h0) |-> $stable(m_sdo_r))
        else $error("serial bit changed inside its period");
    a_read_after: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        m_start && !read_mode_sel |-> !busy_r)
        else $error("read started during conversion");
    a_overrun_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        overrun |=> incomplete_read_flag_r ##1 !incomplete_read_flag_r || overrun)
        else $error("incomplete read not flagged");
    a_sclk_dir: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ser && out_en |=> pin_oe_r[PIN_SCLK] == !$past(clock_source_select))
        else $error("serial clock direction wrong");
endmodule

/* File: testbench/adcop_host_model.sv */
// host side model: reads results from the serial port in master and slave mode
// assumes pins arrive as registered values of the port; makes the link clock itself
`timescale 1ns/10ps
module adcop_host_model (
    input  wire logic        sys_clk_i,
    input  wire logic        ext_mode_i,
    input  wire logic        invert_i,
    input  wire logic        sync_inv_i,
    input  wire logic [15:0] pin_d_i,
    input  wire logic [15:0] pin_oe_i,
    output logic             ext_sclk_o,
    output logic             chain_o,
    output logic [15:0]      word_o,
    output logic [7:0]       chain_word_o,
    output logic             got_o,
    output int               err_o
);
    logic sck_raw;
    logic sclk_q;
    logic bit_q;
    logic frame;
    int   cnt;

    initial begin
        sck_raw = 1'b0;
        chain_o = 1'b0;
        got_o   = 1'b0;
        err_o   = 0;
        cnt     = 0;
    end

    // clock idles at the inverted level so the first toggle is always the update edge
    assign ext_sclk_o = sck_raw ^ invert_i;
    assign frame      = pin_oe_i[10] && (pin_d_i[10] != sync_inv_i);

    ////////////////////////////////////////////////////////////////////////////////
    // master mode: capture on the rising clock, confirm the bit on the falling one
    always @(posedge sys_clk_i) begin
        if (!ext_mode_i && frame) begin
            if (pin_d_i[9] && !sclk_q) begin
                word_o <= {word_o[14:0], pin_d_i[8]};
                bit_q  <= pin_d_i[8];
                cnt    <= cnt + 1;
            end
            if (!pin_d_i[9] && sclk_q && pin_d_i[8] != bit_q) err_o <= err_o + 1;
        end else if (!ext_mode_i) begin
            if (cnt != 0 && cnt != 16) err_o <= err_o + 1;
            cnt <= 0;
        end
        got_o  <= !ext_mode_i && frame && pin_d_i[9] && !sclk_q && cnt == 15;
        sclk_q <= pin_d_i[9];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // slave mode: one 80 ns period per bit, sample on the edge opposite the update
    task automatic slave_read(input int n, input logic [7:0] pat);
        logic [23:0] sh;
        chain_o = pat[7];
        for (int i = 0; i < n; i++) begin
            sck_raw = 1'b1;
            #40;
            sck_raw = 1'b0;
            sh      = {sh[22:0], pin_d_i[8]};
            chain_o = pat[(6 - i) & 7];
            #40;
        end
        if (n >= 16) begin
            word_o       = (n > 16) ? sh[23:8] : sh[15:0];
            chain_word_o = sh[7:0];
            got_o        = 1'b1;
            #25;
            got_o        = 1'b0;
        end
    endtask
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench of the result output port: parallel, master and slave reads
// assumes the host model is compiled before this file
`timescale 1ns/10ps
module tb_top;
    import adcop_pkg::*;
    logic        sys_clk_i, rst_i, conv_start, res_valid, ser, cod, cs_n, rd_n;
    logic        ext, inv, sinv, rdc, res_ready, busy, ext_sclk, chain, hgot;
    logic [15:0] res_data, pin_d, pin_oe, w, hword;
    logic [7:0]  pat, hchain;
    logic [15:0] exp_q[$];
    int          mismatches, n_checks, seed, cyc, flag_cnt, herr, k, npush;

    adcop_top uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ext_sclk_i(ext_sclk),
        .conv_start_i(conv_start), .res_valid_i(res_valid), .res_ready_o(res_ready),
        .res_data_i(res_data), .busy_o(busy), .serial_mode_select_i(ser),
        .output_coding_select_i(cod), .cs_n_i(cs_n), .rd_n_i(rd_n),
        .pin_d_i({(ext ? chain : rdc), inv, sinv, ext}), .pin_d_o(pin_d), .pin_d_oe_o(pin_oe));

    adcop_host_model host (.sys_clk_i(sys_clk_i), .ext_mode_i(ext), .invert_i(inv),
        .sync_inv_i(sinv), .pin_d_i(pin_d), .pin_oe_i(ser ? pin_oe : 16'h0000),
        .ext_sclk_o(ext_sclk),
        .chain_o(chain), .word_o(hword), .chain_word_o(hchain), .got_o(hgot), .err_o(herr));

    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ready is sampled before the edge; it only moves on edges
    task automatic push(input logic [15:0] d);
        logic ok;
        res_valid = 1'b1;
        res_data  = d;
        do begin
            ok = res_ready;
            tick();
        end while (!ok);
        res_valid = 1'b0;
    endtask

    task automatic conv();
        conv_start = 1'b1;
        tick();
        conv_start = 1'b0;
        check({15'h0, busy}, 16'h0001);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // result watchers: oldest note against what the port shows
    always @(posedge hgot) begin
        #1;
        check(hword, exp_q.size() ? exp_q.pop_front() : ~hword);
    end

    always @(negedge busy) if (!ser && !rst_i) begin
        tick();
        check(pin_d, exp_q.size() ? exp_q.pop_front() : ~pin_d);
    end

    always @(posedge sys_clk_i) begin
        cyc++;
        if (ser && ext && pin_oe[11] && pin_d[11] === 1'b1) flag_cnt++;
        if (cyc == 20000) begin
            mismatches++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed       = 24950;
        rst_i      = 1'b1;
        conv_start = 1'b0;
        res_valid  = 1'b0;
        res_data   = 16'h0000;
        {ser, cod, cs_n, rd_n, ext, inv, sinv, rdc} = 8'h31;
        tick(4);
        check(pin_oe, 16'hf000);
        rst_i = 1'b0;
        cs_n  = 1'b0;
        rd_n  = 1'b0;
        tick(4);
        check(pin_oe, 16'hffff);
        for (k = 0; k < 2; k++) begin
            cod = k[0];
            tick(4);
            w = $random(seed);
            exp_q.push_back(cod ? w : w ^ 16'h8000);
            conv();
            push(w);
            tick(6);
        end
        cs_n = 1'b1;
        tick(4);
        check(pin_oe, 16'hf000);
        $display("test parallel done");

        // master: read during or after conversion, both sync polarities
        ser = 1'b1;
        for (k = 0; k < 4; k++) begin
            {sinv, rdc} = k[1:0];
            cs_n = 1'b1;
            rd_n = 1'b1;
            tick(4);
            w = $random(seed);
            push(w);
            tick(3);
            conv();
            if (rdc) exp_q.push_back(w);
            cs_n = 1'b0;
            rd_n = 1'b0;
            tick(12);
            check(pin_oe, 16'hf700);
            check({15'h0, pin_d[10]}, {15'h0, rdc ^ sinv});
            // frame running stalls the buffer until it refuses
            npush = 0;
            while (res_ready) begin
                w = $random(seed);
                exp_q.push_back(w);
                push(w);
                npush++;
                tick();
            end
            check(16'(npush), rdc ? 16'h0002 : 16'h0003);
            while (exp_q.size() != 0) tick();
            tick(8);
            $display("test master mode %0d polarity %0d done", rdc, sinv);
        end

        // slave: both update edges, chained bits after the result
        ext = 1'b1;
        for (k = 0; k < 2; k++) begin
            cs_n = 1'b1;
            rd_n = 1'b1;
            tick();
            // strap moves only with the link held in reset
            inv  = k[0];
            tick(4);
            w   = $random(seed);
            pat = $random(seed);
            push(w);
            host.slave_read(5, 8'h00);
            cs_n = 1'b0;
            rd_n = 1'b0;
            tick(4);
            check(pin_oe, 16'hf900);
            exp_q.push_back(w);
            host.slave_read(24, pat);
            check({8'h00, hchain}, {8'h00, pat});
            tick();
            $display("test slave invert %0d done", inv);
        end

        // a new result during an unfinished read replaces the word
        cs_n = 1'b1;
        tick(4);
        w = $random(seed);
        push(w);
        tick(4);
        cs_n = 1'b0;
        tick(4);
        host.slave_read(6, 8'h00);
        tick(6);
        flag_cnt = 0;
        w = $random(seed);
        push(w);
        tick(10);
        check(16'(flag_cnt), 16'h0001);
        cs_n = 1'b1;
        tick(4);
        cs_n = 1'b0;
        tick(4);
        exp_q.push_back(w);
        host.slave_read(16, 8'h00);
        tick();
        check(16'(herr), 16'h0000);
        $display("test overrun done");
        final_report();
    end
endmodule
